/* File: rtl/emp_pkg.sv */
// Package for the external memory port pin sequencer
package emp_pkg;
    localparam int CLK_PERIOD_NS      = 4;        // Core clock period
    localparam int ADDR_W             = 18;       // Internal address width
    localparam int LOW_ADDR_W         = 15;       // Plain SRAM address lines
    localparam int DRAM_ADDR_W        = 11;       // Multiplexed DRAM lines
    localparam int DATA_W             = 8;        // Full data bus width
    localparam int NIBBLE_W           = 4;        // Narrow data bus width
    localparam int PHASE_CNT_W        = 4;        // Width of phase counter
    localparam logic [3:0] SRAM_STROBE_CYC = 4'h2; // SRAM strobe hold cycles
    localparam logic [3:0] DRAM_PHASE_CYC  = 4'h2; // Cycles per DRAM phase
    localparam logic [LOW_ADDR_W-1:0] ADDR_RST = 15'h7fff; // Address lines high at reset

    // Role of a shared address/select line during SRAM cycles
    typedef enum logic {
        EMP_LINE_ADDR,
        EMP_LINE_CSEL
    } emp_line_mode_t;

    // One access request from the core
    typedef struct packed {
        logic                  write;  // 1 write, 0 read
        logic                  dram;   // 1 DRAM, 0 SRAM
        logic [1:0]            csel;   // SRAM chip select number
        logic [ADDR_W-1:0]     addr;   // Word address
        logic [DATA_W-1:0]     wdata;  // Write data
    } emp_req_t;

    // Static port configuration
    typedef struct packed {
        logic                  narrow;  // 1 four-bit data bus
        emp_line_mode_t        mode15;  // Line 15 role
        emp_line_mode_t        mode16;  // Line 16 role
        emp_line_mode_t        mode17;  // Line 17 role
    } emp_cfg_t;
endpackage

/* File: rtl/emp_port.sv */
// External memory port pin sequencer for SRAM and DRAM cycles
// Contract
// - DRAM row then column on low eleven lines
// - SRAM drives address bits 0-14 plainly
// - Line 15 is address 15 or select 3
// - Line 16 is address 16 or select 2
// - Line 16 is column strobe for DRAM
// - Line 17 is address 17 or select 1
// - Line 17 is row strobe for DRAM
// - Dedicated output is chip select 0
// - Write strobe only during write cycles
// - Read strobe only during read cycles
// - Data in on read, out on write, else off
// - Four-bit mode keeps upper nibble tri-stated
`timescale 1ns/1ns
module emp_port (
    // Clock and reset
    input  wire  logic                       ref_clk,
    input  wire  logic                       reset,
    // Core side
    input  wire  emp_pkg::emp_cfg_t          cfg,
    input  wire  logic                       req_valid,
    input  wire  emp_pkg::emp_req_t          req,
    output logic                             req_ready,
    output logic                             rsp_valid,
    output logic [emp_pkg::DATA_W-1:0]       rsp_rdata,
    // Memory pins
    output logic [emp_pkg::LOW_ADDR_W-1:0]   mem_addr_low_lines,
    output logic                             mem_addr_bit_fifteen,
    output logic                             mem_addr_bit_sixteen,
    output logic                             mem_addr_bit_seventeen,
    output logic                             mem_chip_sel_zero_n,
    output logic                             mem_write_strobe_n,
    output logic                             mem_read_strobe_n,
    input  wire  logic [emp_pkg::DATA_W-1:0] mem_data_bus_in,
    output logic [emp_pkg::DATA_W-1:0]       mem_data_bus_out,
    output logic [emp_pkg::DATA_W-1:0]       mem_data_bus_oe
);
    import emp_pkg::*;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SRAM,
        ST_DRAM_ROW,
        ST_DRAM_COL,
        ST_DONE
    } emp_state_t;

    emp_state_t              state_q;     // Current phase
    emp_req_t                cur_q;       // Latched request
    logic [PHASE_CNT_W-1:0]  cnt_q;       // Cycles left in phase
    logic [DATA_W-1:0]       rdata_q;     // Captured read data

    // Select decode, one-hot, active low
    function automatic logic [3:0] emp_sel_n(input logic [1:0] num);
        logic [3:0] sel;
        sel = 4'hf;
        sel[num] = 1'b0;
        return sel;
    endfunction

    // Lane enable mask; narrow mode never touches the top nibble
    function automatic logic [DATA_W-1:0] emp_lane_mask(input logic narrow);
        return narrow ? {{(DATA_W-NIBBLE_W){1'b0}}, {NIBBLE_W{1'b1}}}
                      : {DATA_W{1'b1}};
    endfunction

    // Phase sequencing; one access at a time, no queue
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state_q <= ST_IDLE;
            cnt_q   <= '0;
            cur_q   <= '0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    // Take only while ready shows, so the edge after reset is refused
                    if (req_valid && req_ready) begin
                        cur_q   <= req;
                        cnt_q   <= req.dram ? DRAM_PHASE_CYC : SRAM_STROBE_CYC;
                        state_q <= req.dram ? ST_DRAM_ROW : ST_SRAM;
                    end
                end
                ST_SRAM: begin
                    if (cnt_q == 4'h1) begin
                        state_q <= ST_DONE;
                    end else begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                end
                ST_DRAM_ROW: begin
                    // Row phase then column phase
                    if (cnt_q == 4'h1) begin
                        cnt_q   <= DRAM_PHASE_CYC;
                        state_q <= ST_DRAM_COL;
                    end else begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                end
                ST_DRAM_COL: begin
                    if (cnt_q == 4'h1) begin
                        state_q <= ST_DONE;
                    end else begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                end
                ST_DONE: begin
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Next pin values, derived from the state being entered
    emp_state_t              nst;         // State in next cycle
    emp_req_t                nreq;        // Request in next cycle
    logic                    nact;        // Strobe phase next cycle
    logic [3:0]              nsel;        // Selects next cycle, active low
    always_comb begin
        nst  = state_q;
        nreq = cur_q;
        case (state_q)
            ST_IDLE: begin
                if (req_valid && req_ready) begin
                    nreq = req;
                    nst  = req.dram ? ST_DRAM_ROW : ST_SRAM;
                end
            end
            ST_SRAM:     nst = (cnt_q == 4'h1) ? ST_DONE : ST_SRAM;
            ST_DRAM_ROW: nst = (cnt_q == 4'h1) ? ST_DRAM_COL : ST_DRAM_ROW;
            ST_DRAM_COL: nst = (cnt_q == 4'h1) ? ST_DONE : ST_DRAM_COL;
            ST_DONE:     nst = ST_IDLE;
            default:     nst = ST_IDLE;
        endcase
        nact = (nst == ST_SRAM) || (nst == ST_DRAM_ROW) || (nst == ST_DRAM_COL);
        nsel = emp_sel_n(nreq.csel);
    end

    // Address and shared lines; address lines hold last value between cycles, select and strobe roles idle high
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            mem_addr_low_lines     <= ADDR_RST;
            mem_addr_bit_fifteen   <= 1'b1;
            mem_addr_bit_sixteen   <= 1'b1;
            mem_addr_bit_seventeen <= 1'b1;
            mem_chip_sel_zero_n    <= 1'b1;
        end else begin
            // Selects and strobes idle high
            mem_chip_sel_zero_n <= 1'b1;
            if (nst == ST_SRAM) begin
                mem_addr_low_lines <= nreq.addr[LOW_ADDR_W-1:0];
                mem_chip_sel_zero_n <= nsel[0];
                // Shared lines: plain address or select
                mem_addr_bit_fifteen <= (cfg.mode15 == EMP_LINE_CSEL)
                    ? nsel[3] : nreq.addr[15];
                mem_addr_bit_sixteen <= (cfg.mode16 == EMP_LINE_CSEL)
                    ? nsel[2] : nreq.addr[16];
                mem_addr_bit_seventeen <= (cfg.mode17 == EMP_LINE_CSEL)
                    ? nsel[1] : nreq.addr[17];
            end else if (nst == ST_DRAM_ROW) begin
                // Row half on low lines
                mem_addr_low_lines <= {{(LOW_ADDR_W-DRAM_ADDR_W){1'b0}},
                                       nreq.addr[2*DRAM_ADDR_W-1-4 -: DRAM_ADDR_W]};
                mem_addr_bit_seventeen <= 1'b0;
                mem_addr_bit_sixteen   <= 1'b1;
            end else if (nst == ST_DRAM_COL) begin
                // Column half after row
                mem_addr_low_lines <= {{(LOW_ADDR_W-DRAM_ADDR_W){1'b0}},
                                       nreq.addr[DRAM_ADDR_W-1:0]};
                mem_addr_bit_seventeen <= 1'b0;
                mem_addr_bit_sixteen   <= 1'b0;
            end else begin
                // Release DRAM strobes or SRAM-mode selects high
                if (cur_q.dram || cfg.mode16 == EMP_LINE_CSEL) begin
                    mem_addr_bit_sixteen <= 1'b1;
                end
                if (cur_q.dram || cfg.mode17 == EMP_LINE_CSEL) begin
                    mem_addr_bit_seventeen <= 1'b1;
                end
                if (cfg.mode15 == EMP_LINE_CSEL) begin
                    mem_addr_bit_fifteen <= 1'b1;
                end
            end
        end
    end

    // Read and write strobes, only inside an access
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            mem_write_strobe_n <= 1'b1;
            mem_read_strobe_n  <= 1'b1;
        end else begin
            mem_write_strobe_n <= ~(nact && nreq.write);
            mem_read_strobe_n  <= ~(nact && !nreq.write);
        end
    end

    // Data drivers; off whenever no write is under way
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            mem_data_bus_out <= '0;
            mem_data_bus_oe  <= '0;
        end else begin
            mem_data_bus_out <= nreq.wdata & emp_lane_mask(cfg.narrow);
            // Drive only on writes, narrow mask
            mem_data_bus_oe  <= (nact && nreq.write) ? emp_lane_mask(cfg.narrow)
                                                     : {DATA_W{1'b0}};
        end
    end

    // Read capture at last strobe cycle; bus is input then
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rdata_q <= '0;
        end else if ((state_q == ST_SRAM || state_q == ST_DRAM_COL) &&
                     !cur_q.write && cnt_q == 4'h1) begin
            rdata_q <= mem_data_bus_in & emp_lane_mask(cfg.narrow);
        end
    end
    assign rsp_rdata = rdata_q;

    // Handshake to the core
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
        end else begin
            req_ready <= (nst == ST_IDLE);
            rsp_valid <= (state_q != ST_DONE) && (nst == ST_DONE);
        end
    end
endmodule

/* File: testbench/emp_mem_model.sv */
// Behavioural external RAM on the far side of the port
`timescale 1ns/1ns
module emp_mem_model (
    // Clock
    input  wire logic        ref_clk,
    // Pins from the port
    input  wire logic [14:0] addr,
    input  wire logic        wr_n,
    input  wire logic        rd_n,
    input  wire logic [7:0]  dout,
    input  wire logic [7:0]  oe,
    // Data back to the port
    output logic [7:0]       din
);
    logic [7:0] mem_q [256]; // Low address bits only, enough for the bench
    logic [7:0] last_q;      // Last wire value
    // Keep only the bits the port really drives
    always_ff @(posedge ref_clk) begin
        if (!wr_n) begin
            mem_q[addr[7:0]] <= dout & oe;
        end
        last_q <= din;
    end
    // Released bus shows the inverse, so stale data cannot match
    assign din = rd_n ? ~last_q : mem_q[addr[7:0]];
endmodule

/* File: testbench/emp_port_checker.sv */
// Concurrent checks on the memory port pins
`timescale 1ns/1ns
module emp_port_checker (
    // Clock and reset
    input wire logic              ref_clk,
    input wire logic              reset,
    // Core side
    input wire emp_pkg::emp_cfg_t cfg,
    input wire logic              req_ready,
    input wire logic              rsp_valid,
    // Memory pins
    input wire logic [14:0]       mem_addr_low_lines,
    input wire logic              mem_chip_sel_zero_n,
    input wire logic              mem_write_strobe_n,
    input wire logic              mem_read_strobe_n,
    input wire logic [7:0]        mem_data_bus_oe
);
    import emp_pkg::*;
    // One clock domain, so one default clock and disable
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    a_wr_drives: assert property (!mem_write_strobe_n |-> mem_data_bus_oe != 8'h00 && mem_read_strobe_n)
        else $error("write strobe without bus drive");
    a_rd_floats: assert property (!mem_read_strobe_n |-> mem_data_bus_oe == 8'h00 && mem_write_strobe_n)
        else $error("bus driven during read");
    a_idle_float: assert property (req_ready |-> mem_data_bus_oe == 8'h00)
        else $error("bus driven while idle");
    a_narrow_upper: assert property (cfg.narrow |-> mem_data_bus_oe[7:4] == 4'h0)
        else $error("upper lines driven in narrow mode");
    a_idle_high: assert property (req_ready |-> mem_write_strobe_n && mem_read_strobe_n && mem_chip_sel_zero_n)
        else $error("strobe or select low while idle");
    a_sel_width: assert property ($fell(mem_chip_sel_zero_n) |=> !mem_chip_sel_zero_n ##1 mem_chip_sel_zero_n)
        else $error("select zero width wrong");
    a_sel_addr: assert property (!mem_chip_sel_zero_n && !$fell(mem_chip_sel_zero_n) |-> $stable(mem_addr_low_lines))
        else $error("address moved under select");
    a_done_gap: assert property (rsp_valid |-> mem_write_strobe_n && mem_read_strobe_n && !req_ready ##1 req_ready)
        else $error("access end sequence wrong");
endmodule

bind emp_port emp_port_checker i_emp_port_checker (.ref_clk(ref_clk), .reset(reset), .cfg(cfg),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .mem_addr_low_lines(mem_addr_low_lines),
    .mem_chip_sel_zero_n(mem_chip_sel_zero_n), .mem_write_strobe_n(mem_write_strobe_n),
    .mem_read_strobe_n(mem_read_strobe_n), .mem_data_bus_oe(mem_data_bus_oe));

/* File: testbench/emp_port_tb.sv */
// Self-checking bench for the memory port pin sequencer
`timescale 1ns/1ns
module emp_port_tb;
    import emp_pkg::*;
    logic        ref_clk = 1'b0;           // Core clock
    logic        reset = 1'b1;             // Held for eight cycles
    emp_cfg_t    cfg = '0;                 // Static port setup
    logic        req_valid = 1'b0;         // Request strobe
    emp_req_t    req = '0;                 // Request fields
    logic        req_ready, rsp_valid;     // Handshake
    logic [7:0]  rsp_rdata, d_in, d_out, d_oe;
    logic [14:0] a_lo;                     // Low address lines
    logic        a15, a16, a17, cs0_n, wr_n, rd_n;
    int          fails = 0;
    int          n_compared = 0;
    always #2 ref_clk = ~ref_clk;
    emp_port i_emp_port (.ref_clk(ref_clk), .reset(reset), .cfg(cfg), .req_valid(req_valid),
        .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .mem_addr_low_lines(a_lo), .mem_addr_bit_fifteen(a15), .mem_addr_bit_sixteen(a16),
        .mem_addr_bit_seventeen(a17), .mem_chip_sel_zero_n(cs0_n), .mem_write_strobe_n(wr_n),
        .mem_read_strobe_n(rd_n), .mem_data_bus_in(d_in), .mem_data_bus_out(d_out),
        .mem_data_bus_oe(d_oe));
    emp_mem_model i_emp_mem_model (.ref_clk(ref_clk), .addr(a_lo), .wr_n(wr_n), .rd_n(rd_n),
        .dout(d_out), .oe(d_oe), .din(d_in));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Expected level of a shared line: active-low select or address bit
    function automatic logic ln(emp_line_mode_t m, logic sel_n, logic a);
        return (m == EMP_LINE_CSEL) ? sel_n : a;
    endfunction
    // One access; pins judged in the first strobe cycle (row phase, then column phase for DRAM)
    task automatic acc(input logic w, dr, input logic [1:0] cs, input logic [17:0] ad,
                       input logic [7:0] wd, exp_rd);
        int n;
        n = 0;
        @(negedge ref_clk);
        req_valid = 1'b1;
        req = '{write: w, dram: dr, csel: cs, addr: ad, wdata: wd};
        while (req_ready !== 1'b1 && n < 20) begin @(negedge ref_clk); n++; end
        @(negedge ref_clk);
        req_valid = 1'b0;
        if (dr) begin
            chk({a_lo, a17, a16}, {4'h0, ad[17:7], 2'b01});
            repeat (2) @(negedge ref_clk);
            chk({a_lo, a17, a16}, {4'h0, ad[10:0], 2'b00});
        end else begin
            chk({a_lo, a17, a16, a15, cs0_n}, {ad[14:0], ln(cfg.mode17, cs != 1, ad[17]),
                ln(cfg.mode16, cs != 2, ad[16]), ln(cfg.mode15, cs != 3, ad[15]), cs != 0});
        end
        chk({wr_n, rd_n, d_oe}, {!w, w, w ? (cfg.narrow ? 8'h0f : 8'hff) : 8'h00});
        n = 0;
        while (rsp_valid !== 1'b1 && n < 10) begin @(negedge ref_clk); n++; end
        chk({rsp_valid, wr_n, rd_n, cs0_n, n[3:0]}, 8'hf2);
        if (dr) chk({a17, a16}, 2'b11);
        if (!w) chk(rsp_rdata, exp_rd);
    endtask
    task automatic t_sram();
        cfg = '{1'b0, EMP_LINE_CSEL, EMP_LINE_CSEL, EMP_LINE_CSEL};
        for (int i = 0; i < 4; i++) begin
            acc(1'b1, 1'b0, i[1:0], 18'h05a40 + 18'(i), 8'hc3 ^ 8'(i), 8'h00);
            acc(1'b0, 1'b0, i[1:0], 18'h05a40 + 18'(i), 8'h00, 8'hc3 ^ 8'(i));
        end
        $display("t_sram done");
    endtask
    // Address mode on all shared lines, then a four-bit bus
    task automatic t_addr();
        cfg = '{1'b0, EMP_LINE_ADDR, EMP_LINE_ADDR, EMP_LINE_ADDR};
        acc(1'b1, 1'b0, 2'h1, 18'h2a5f1, 8'h96, 8'h00);
        acc(1'b0, 1'b0, 2'h3, 18'h2a5f1, 8'h00, 8'h96);
        cfg.narrow = 1'b1;
        acc(1'b1, 1'b0, 2'h0, 18'h15a33, 8'h5c, 8'h00);
        acc(1'b0, 1'b0, 2'h0, 18'h15a33, 8'h00, 8'h0c);
        $display("t_addr done");
    endtask
    task automatic t_dram();
        cfg.narrow = 1'b0;
        acc(1'b1, 1'b1, 2'h0, 18'h3c5a1, 8'h3e, 8'h00);
        acc(1'b0, 1'b1, 2'h0, 18'h3c5a1, 8'h00, 8'h3e);
        $display("t_dram done");
    endtask
    initial begin
        repeat (8) @(negedge ref_clk);
        chk({a_lo, a15, a16, a17, cs0_n, wr_n, rd_n, d_oe}, {15'h7fff, 6'h3f, 8'h00});
        reset = 1'b0;
        t_sram();
        t_addr();
        t_dram();
        test_done();
    end
    // Watchdog at 2000 cycles, well beyond the 70 or so cycles the tests need
    initial begin
        #8000;
        fails++;
        test_done();
    end
endmodule
